// ===== acfr_pkg.sv
package acfr_pkg;
    // shared buffer geometry
    localparam int BUF_QUADS = 378;
    localparam int NQ = 6;
    // queue indices, in buffer order
    localparam logic [2:0] Q_MTX = 3'h0;
    localparam logic [2:0] Q_MRX = 3'h1;
    localparam logic [2:0] Q_CTX = 3'h2;
    localparam logic [2:0] Q_CRX = 3'h3;
    localparam logic [2:0] Q_GTX = 3'h4;
    localparam logic [2:0] Q_GRX = 3'h5;
    // queue sizes in quadlets
    localparam logic [8:0] MTX_SIZE = 9'h003;
    localparam logic [8:0] MRX_SIZE = 9'h00F;
    localparam logic [8:0] CTX_SIZE_RST = 9'h00C;
    localparam logic [8:0] CRX_SIZE_RST = 9'h03C;
    localparam logic [8:0] GTX_SIZE_RST = 9'h020;
    localparam logic [8:0] GRX_SIZE_RST = 9'h100;
    // register offsets
    localparam logic [7:0] OFS_GTX_STAT = 8'h2C;
    localparam logic [7:0] OFS_GRX_STAT = 8'h30;
    localparam logic [7:0] OFS_MTX_STAT = 8'h34;
    localparam logic [7:0] OFS_MRX_STAT = 8'h38;
    localparam logic [7:0] OFS_CTX_STAT = 8'h3C;
    localparam logic [7:0] OFS_CRX_STAT = 8'h40;
    localparam logic [7:0] OFS_ORB_CTRL = 8'h44;
    localparam logic [7:0] OFS_USTAT = 8'h50;
    localparam logic [7:0] OFS_TX_FIRST = 8'h70;
    localparam logic [7:0] OFS_TX_NEXT = 8'h74;
    localparam logic [7:0] OFS_TX_FINAL = 8'h78;
    localparam logic [7:0] OFS_GRX_READ = 8'h80;
    localparam logic [7:0] OFS_MRX_READ = 8'h84;
    localparam logic [7:0] OFS_CRX_READ = 8'h88;
    // field positions and reset values
    localparam int STAT_CLR_BIT = 31;
    localparam int STAT_ERR_BIT = 30;
    localparam int STAT_CNT_LSB = 16;
    localparam logic [7:0] ORB_SIZE_RST = 8'h08;
    localparam int ORB_SHORT_BIT = 8;
    localparam int UST_IRQ_EN_BIT = 0;
    localparam int UST_EN_BIT = 1;
    localparam int TLABEL_LSB = 10;
    localparam int TCODE_LSB = 4;
    // transaction codes
    localparam logic [3:0] TC_WR_BLK = 4'h1;
    localparam logic [3:0] TC_WR_RESP = 4'h2;
    localparam logic [3:0] TC_RD_BLK = 4'h5;
    localparam logic [3:0] TC_RD_QRESP = 4'h6;
    localparam logic [3:0] TC_RD_BRESP = 4'h7;
    localparam logic [3:0] TC_LOCK_RESP = 4'hB;
    typedef enum logic [2:0] {
        DST_NONE = 3'h0,
        DST_GEN = 3'h1,
        DST_MGMT = 3'h2,
        DST_CMD = 3'h3,
        DST_DMA = 3'h4
    } acfr_dst_t;
    typedef enum logic {
        HW_IDLE = 1'b0,
        HW_FILL = 1'b1
    } acfr_hw_t;
endpackage : acfr_pkg

// ===== acfr_store.sv
`timescale 1ns/1ps
module acfr_store import acfr_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host side write and read
    input wire logic we0,
    input wire logic [8:0] wa0,
    input wire logic [31:0] wd0,
    input wire logic [8:0] ra0,
    output logic [31:0] rd0,
    // link side write and read
    input wire logic we1,
    input wire logic [8:0] wa1,
    input wire logic [31:0] wd1,
    input wire logic [8:0] ra1,
    output logic [31:0] rd1
);
    typedef struct packed {
        logic [BUF_QUADS-1:0][31:0] mem;
    } acfr_mem_t;
    acfr_mem_t m_reg;
    acfr_mem_t m_next;
    // the two writers always target different queues
    always_comb begin
        m_next = m_reg;
        if (we0 && (32'(wa0) < BUF_QUADS)) begin
            m_next.mem[wa0] = wd0;
        end
        if (we1 && (32'(wa1) < BUF_QUADS)) begin
            m_next.mem[wa1] = wd1;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            m_reg <= '0;
        end else begin
            m_reg <= m_next;
        end
    end
    assign rd0 = (32'(ra0) < BUF_QUADS) ? m_reg.mem[ra0] : 32'h0000_0000;
    assign rd1 = (32'(ra1) < BUF_QUADS) ? m_reg.mem[ra1] : 32'h0000_0000;
endmodule : acfr_store

// ===== acfr_route.sv
`timescale 1ns/1ps
module acfr_route import acfr_pkg::*; (
    // transmit header from the host
    input wire logic [31:0] tx_hdr,
    output logic [2:0] tx_q,
    output logic tx_expect,
    output logic tx_unsol,
    // receive header from the link
    input wire logic [31:0] rx_hdr,
    output acfr_dst_t rx_dst
);
    function automatic logic is_resp(input logic [3:0] tc);
        is_resp = (tc == TC_WR_RESP) || (tc == TC_RD_QRESP) ||
                  (tc == TC_RD_BRESP) || (tc == TC_LOCK_RESP);
    endfunction : is_resp
    logic [5:0] tl;
    logic [3:0] tc;
    logic [5:0] rl;
    logic [3:0] rc;
    assign tl = tx_hdr[TLABEL_LSB +: 6];
    assign tc = tx_hdr[TCODE_LSB +: 4];
    assign rl = rx_hdr[TLABEL_LSB +: 6];
    assign rc = rx_hdr[TCODE_LSB +: 4];
    always_comb begin
        tx_q = Q_GTX;
        tx_expect = 1'b1;
        tx_unsol = 1'b0;
        if (is_resp(tc)) begin
            tx_expect = 1'b0;
        end else if (tl[5:2] == 4'h8 && tc == TC_RD_BLK) begin
            tx_q = Q_MTX;
        end else if (tl[5:2] == 4'hC && tc == TC_RD_BLK) begin
            tx_q = Q_CTX;
        end else begin
            tx_unsol = (tl[5:3] == 3'h7) && (tc == TC_WR_BLK);
        end
    end
    // requests from the far end are not ours to queue here
    always_comb begin
        if (!is_resp(rc)) begin
            rx_dst = DST_NONE;
        end else if (rl[5:4] == 2'h1) begin
            rx_dst = DST_DMA;
        end else if (rl[5:2] == 4'h8 || rl == 6'h28) begin
            rx_dst = DST_MGMT;
        end else if (rl[5:2] == 4'hC) begin
            rx_dst = DST_CMD;
        end else if (rl[5:3] == 3'h7) begin
            rx_dst = (rc == TC_RD_BRESP) ? DST_CMD : DST_GEN;
        end else begin
            rx_dst = DST_GEN;
        end
    end
endmodule : acfr_route

// ===== acfr_top.sv
`timescale 1ns/1ps
// Contract
// - one shared 378-quadlet buffer for six queues
// - management queues fixed at 3 and 15
// - orb size field resets to 8
// - general queues take the rest, one tx packet
// - packets enter only through three write ports
// - three read ports, one per receive queue
// - responses steered by shared transaction label
// - responses and low labels use general queues
// - label 10_00xx block read uses management queues
// - label 11_00xx block read uses command queues
// - label 11_1xxx block write is unsolicited status
// - unsolicited send clears enable when irq enabled
// - unified write completion delivers no response
// - reserved labels belong to automatic transfers
// - general request label 01_xxxx answers to dma
module acfr_top import acfr_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    // link transmit stream
    output logic tx_valid,
    output logic [31:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    input wire logic tx_unified,
    // link receive stream
    input wire logic rx_valid,
    input wire logic rx_first,
    input wire logic [31:0] rx_data,
    output logic rx_ready,
    // dma receive hand-off
    output logic dma_valid,
    output logic [31:0] dma_data,
    input wire logic dma_ready
);
    typedef struct packed {
        logic [NQ-1:0][8:0] wp;
        logic [NQ-1:0][8:0] rp;
        logic [NQ-1:0][8:0] cnt;
        logic [NQ-1:0][8:0] size;
        logic [NQ-1:0] err;
        logic [2:0] pend;
        logic [2:0] t_exp;
        logic [2:0] t_uns;
        acfr_hw_t hw_st;
        logic [2:0] hw_q;
        logic tx_act;
        logic [1:0] tx_sel;
        logic [8:0] tx_left;
        logic [7:0] orb_size;
        logic short_fmt;
        logic ust_irq_en;
        logic ust_en;
        logic gen_await;
        acfr_dst_t rx_dst;
        logic [31:0] rdata;
    } acfr_state_t;
    acfr_state_t s_reg;
    acfr_state_t s_next;
    // transmit slots: 0 management, 1 command, 2 general
    function automatic logic [2:0] slot_q(input logic [1:0] t);
        case (t)
            2'h0: slot_q = Q_MTX;
            2'h1: slot_q = Q_CTX;
            default: slot_q = Q_GTX;
        endcase
    endfunction : slot_q
    function automatic logic [1:0] q_slot(input logic [2:0] q);
        case (q)
            Q_MTX: q_slot = 2'h0;
            Q_CTX: q_slot = 2'h1;
            default: q_slot = 2'h2;
        endcase
    endfunction : q_slot
    function automatic logic [2:0] dst_q(input acfr_dst_t d);
        case (d)
            DST_MGMT: dst_q = Q_MRX;
            DST_CMD: dst_q = Q_CRX;
            default: dst_q = Q_GRX;
        endcase
    endfunction : dst_q
    function automatic logic [7:0] stat_ofs(input logic [2:0] q);
        case (q)
            Q_MTX: stat_ofs = OFS_MTX_STAT;
            Q_MRX: stat_ofs = OFS_MRX_STAT;
            Q_CTX: stat_ofs = OFS_CTX_STAT;
            Q_CRX: stat_ofs = OFS_CRX_STAT;
            Q_GTX: stat_ofs = OFS_GTX_STAT;
            default: stat_ofs = OFS_GRX_STAT;
        endcase
    endfunction : stat_ofs
    function automatic logic [8:0] wrap(input logic [8:0] p, input logic [8:0] sz);
        wrap = (p == sz - 9'h001) ? 9'h000 : p + 9'h001;
    endfunction : wrap
    // routing decode
    logic [2:0] rt_q;
    logic rt_expect;
    logic rt_unsol;
    acfr_dst_t rt_dst;

    acfr_route u_route (
        .tx_hdr(wdata),
        .tx_q(rt_q),
        .tx_expect(rt_expect),
        .tx_unsol(rt_unsol),
        .rx_hdr(rx_data),
        .rx_dst(rt_dst)
    );
    // queue bases follow from the sizes in buffer order
    logic [NQ-1:0][8:0] base;
    always_comb begin
        base[0] = 9'h000;
        for (int i = 1; i < NQ; i++) begin
            base[i] = base[i-1] + s_reg.size[i-1];
        end
    end
    // receive destination of the current word
    acfr_dst_t dst_new;
    acfr_dst_t cur_dst;
    logic [2:0] cur_q;
    always_comb begin
        dst_new = rt_dst;
        // no response is pending after a unified write
        if (rt_dst == DST_GEN && !s_reg.gen_await) begin
            dst_new = DST_NONE;
        end
    end
    assign cur_dst = rx_first ? dst_new : s_reg.rx_dst;
    assign cur_q = dst_q(cur_dst);
    // a full queue stalls the link mid-packet instead of losing words
    always_comb begin
        case (cur_dst)
            DST_NONE: rx_ready = 1'b1;
            DST_DMA: rx_ready = dma_ready;
            default: rx_ready = s_reg.cnt[cur_q] < s_reg.size[cur_q];
        endcase
    end
    assign dma_valid = rx_valid && (cur_dst == DST_DMA);
    assign dma_data = rx_data;

    // host read port select
    logic [2:0] hr_q;
    logic hr_hit;
    always_comb begin
        hr_hit = rd_en;
        if (addr == OFS_GRX_READ) begin
            hr_q = Q_GRX;
        end else if (addr == OFS_MRX_READ) begin
            hr_q = Q_MRX;
        end else if (addr == OFS_CRX_READ) begin
            hr_q = Q_CRX;
        end else begin
            hr_q = Q_GRX;
            hr_hit = 1'b0;
        end
    end

    // buffer access
    logic [2:0] tx_q;
    logic hw_we;
    logic [2:0] hw_wq;
    logic rx_we;
    logic [31:0] rd0;
    logic [31:0] rd1;
    assign tx_q = slot_q(s_reg.tx_sel);
    assign rx_we = rx_valid && rx_ready && (cur_dst != DST_NONE) && (cur_dst != DST_DMA);

    acfr_store u_store (
        .clk(clk),
        .rst_n(rst_n),
        .we0(hw_we),
        .wa0(base[hw_wq] + s_reg.wp[hw_wq]),
        .wd0(wdata),
        .ra0(base[hr_q] + s_reg.rp[hr_q]),
        .rd0(rd0),
        .we1(rx_we),
        .wa1(base[cur_q] + s_reg.wp[cur_q]),
        .wd1(rx_data),
        .ra1(base[tx_q] + s_reg.rp[tx_q]),
        .rd1(rd1)
    );

    assign tx_valid = s_reg.tx_act;
    assign tx_data = rd1;
    assign tx_last = s_reg.tx_act && (s_reg.tx_left == 9'h001);
    assign rdata = s_reg.rdata;

    logic [NQ-1:0] push;
    logic [NQ-1:0] pop;
    logic [NQ-1:0] clr;
    always_comb begin
        s_next = s_reg;
        s_next.rdata = 32'h0000_0000;
        hw_we = 1'b0;
        hw_wq = s_reg.hw_q;
        push = '0;
        pop = '0;
        clr = '0;

        // host transmit ports
        if (wr_en && addr == OFS_TX_FIRST) begin
            // each transmit queue holds one packet, so a busy queue refuses
            if (s_reg.cnt[rt_q] == 9'h000 && !s_reg.pend[q_slot(rt_q)]) begin
                hw_we = 1'b1;
                hw_wq = rt_q;
                s_next.hw_st = HW_FILL;
                s_next.hw_q = rt_q;
                s_next.t_exp[q_slot(rt_q)] = rt_expect;
                s_next.t_uns[q_slot(rt_q)] = rt_unsol;
            end else begin
                s_next.err[rt_q] = 1'b1;
            end
        end else if (wr_en && (addr == OFS_TX_NEXT || addr == OFS_TX_FINAL)) begin
            case (s_reg.hw_st)
                HW_FILL: begin
                    if (s_reg.cnt[s_reg.hw_q] < s_reg.size[s_reg.hw_q]) begin
                        hw_we = 1'b1;
                    end else begin
                        s_next.err[s_reg.hw_q] = 1'b1;
                    end
                    if (addr == OFS_TX_FINAL) begin
                        s_next.pend[q_slot(s_reg.hw_q)] = 1'b1;
                        s_next.hw_st = HW_IDLE;
                    end
                end
                default: begin
                    s_next.hw_st = HW_IDLE;
                end
            endcase
        end
        push[hw_wq] = hw_we;

        // link receive
        if (rx_valid && rx_ready) begin
            if (rx_first) begin
                s_next.rx_dst = cur_dst;
                if (cur_dst == DST_GEN) begin
                    s_next.gen_await = 1'b0;
                end
            end
            push[cur_q] = push[cur_q] | rx_we;
        end

        // link transmit, management first, then command, then general
        if (!s_reg.tx_act) begin
            for (int t = 2; t >= 0; t--) begin
                if (s_reg.pend[t] && s_reg.cnt[slot_q(2'(t))] != 9'h000) begin
                    s_next.tx_act = 1'b1;
                    s_next.tx_sel = 2'(t);
                    s_next.tx_left = s_reg.cnt[slot_q(2'(t))];
                end
            end
        end else if (tx_ready) begin
            pop[tx_q] = 1'b1;
            s_next.tx_left = s_reg.tx_left - 9'h001;
            if (tx_last) begin
                s_next.tx_act = 1'b0;
                s_next.pend[s_reg.tx_sel] = 1'b0;
                if (s_reg.tx_sel == 2'h2) begin
                    if (s_reg.t_uns[2] && s_reg.ust_irq_en) begin
                        s_next.ust_en = 1'b0;
                    end
                    if (s_reg.t_exp[2] && !tx_unified) begin
                        s_next.gen_await = 1'b1;
                    end
                end
            end
        end

        // host reads
        if (hr_hit && s_reg.cnt[hr_q] != 9'h000) begin
            s_next.rdata = rd0;
            pop[hr_q] = 1'b1;
        end else if (rd_en) begin
            for (int i = 0; i < NQ; i++) begin
                if (addr == stat_ofs(3'(i))) begin
                    s_next.rdata = {1'b0, s_reg.err[i], 5'h00, s_reg.cnt[i], 7'h00,
                                    s_reg.size[i]};
                end
            end
            if (addr == OFS_ORB_CTRL) begin
                s_next.rdata = {23'h000000, s_reg.short_fmt, s_reg.orb_size};
            end else if (addr == OFS_USTAT) begin
                s_next.rdata = {30'h00000000, s_reg.ust_en, s_reg.ust_irq_en};
            end
        end

        // configuration writes; a software set of the enable beats the auto clear
        if (wr_en) begin
            for (int i = 0; i < NQ; i++) begin
                if (addr == stat_ofs(3'(i))) begin
                    clr[i] = wdata[STAT_CLR_BIT];
                    if (3'(i) != Q_MTX && 3'(i) != Q_MRX) begin
                        s_next.size[i] = wdata[8:0];
                    end
                end
            end
            if (addr == OFS_ORB_CTRL) begin
                s_next.orb_size = wdata[7:0];
                s_next.short_fmt = wdata[ORB_SHORT_BIT];
            end else if (addr == OFS_USTAT) begin
                s_next.ust_irq_en = wdata[UST_IRQ_EN_BIT];
                s_next.ust_en = wdata[UST_EN_BIT];
            end
        end

        // occupancy and pointers
        for (int i = 0; i < NQ; i++) begin
            if (push[i]) begin
                s_next.wp[i] = wrap(s_reg.wp[i], s_reg.size[i]);
            end
            if (pop[i]) begin
                s_next.rp[i] = wrap(s_reg.rp[i], s_reg.size[i]);
            end
            case ({push[i], pop[i]})
                2'b10: s_next.cnt[i] = s_reg.cnt[i] + 9'h001;
                2'b01: s_next.cnt[i] = s_reg.cnt[i] - 9'h001;
                default: s_next.cnt[i] = s_reg.cnt[i];
            endcase
        end

        // clearing a queue empties it; contents after a resize are not trusted
        for (int i = 0; i < NQ; i++) begin
            if (clr[i]) begin
                s_next.wp[i] = 9'h000;
                s_next.rp[i] = 9'h000;
                s_next.cnt[i] = 9'h000;
                s_next.err[i] = 1'b0;
                if (3'(i) == Q_MTX || 3'(i) == Q_CTX || 3'(i) == Q_GTX) begin
                    s_next.pend[q_slot(3'(i))] = 1'b0;
                    if (s_reg.tx_act && s_reg.tx_sel == q_slot(3'(i))) begin
                        s_next.tx_act = 1'b0;
                    end
                    if (s_reg.hw_q == 3'(i)) begin
                        s_next.hw_st = HW_IDLE;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.size[Q_MTX] <= MTX_SIZE;
            s_reg.size[Q_MRX] <= MRX_SIZE;
            s_reg.size[Q_CTX] <= CTX_SIZE_RST;
            s_reg.size[Q_CRX] <= CRX_SIZE_RST;
            s_reg.size[Q_GTX] <= GTX_SIZE_RST;
            s_reg.size[Q_GRX] <= GRX_SIZE_RST;
            s_reg.orb_size <= ORB_SIZE_RST;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : acfr_top

// ===== acfr_checker.sv
`timescale 1ns/1ps
module acfr_checker import acfr_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] addr,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    // link streams
    input wire logic tx_valid,
    input wire logic [31:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic rx_first,
    input wire logic [31:0] rx_data,
    input wire logic rx_ready,
    input wire logic dma_valid,
    input wire logic [31:0] dma_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd(a); rd_en && addr == a; endsequence
    sequence s_tx_end; tx_valid && tx_ready && tx_last; endsequence
    sequence s_req_hdr;
        rx_valid && rx_first && (rx_data[7:4] == TC_WR_BLK || rx_data[7:4] == TC_RD_BLK);
    endsequence
    sequence s_dma_hdr;
        rx_valid && rx_first && rx_data[15:14] == 2'b01 && rx_data[7:4] == TC_RD_BRESP;
    endsequence
    property p_rdata_idle; !$past(rd_en) |-> rdata == 32'h0; endproperty
    property p_unmapped; s_rd(8'h7C) |=> rdata == 32'h0; endproperty
    property p_mtx_size; s_rd(OFS_MTX_STAT) |=> rdata[8:0] == MTX_SIZE; endproperty
    property p_mrx_size; s_rd(OFS_MRX_STAT) |=> rdata[8:0] == MRX_SIZE; endproperty
    property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
    property p_tx_gap; s_tx_end |=> !tx_valid; endproperty
    property p_last_valid; tx_last |-> tx_valid; endproperty
    property p_dma_pass;
        dma_valid |-> rx_valid && dma_data == rx_data && (!rx_first || rx_data[15:14] == 2'b01);
    endproperty
    property p_req_drop; s_req_hdr |-> rx_ready && !dma_valid; endproperty
    property p_dma_route; s_dma_hdr |-> dma_valid; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata set without read");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_mtx_size: assert property (p_mtx_size) else $error("mgmt tx size wrong");
    a_mrx_size: assert property (p_mrx_size) else $error("mgmt rx size wrong");
    a_tx_hold: assert property (p_tx_hold) else $error("tx word not held");
    a_tx_gap: assert property (p_tx_gap) else $error("no gap after last");
    a_last_valid: assert property (p_last_valid) else $error("last without valid");
    a_dma_pass: assert property (p_dma_pass) else $error("dma data differs");
    a_req_drop: assert property (p_req_drop) else $error("request not dropped");
    a_dma_route: assert property (p_dma_route) else $error("dma label not steered");
endmodule : acfr_checker

bind acfr_top acfr_checker u_acfr_checker (.clk(clk), .rst_n(rst_n), .addr(addr),
    .rd_en(rd_en), .rdata(rdata), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_first(rx_first),
    .rx_data(rx_data), .rx_ready(rx_ready), .dma_valid(dma_valid), .dma_data(dma_data));

// ===== acfr_link_model.sv
`timescale 1ns/1ps
module acfr_link_model import acfr_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // transmit stream
    input wire logic tx_valid,
    input wire logic [31:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready,
    output logic tx_unified,
    // receive stream
    output logic rx_valid,
    output logic rx_first,
    output logic [31:0] rx_data,
    input wire logic rx_ready,
    // dma hand-off
    input wire logic dma_valid,
    input wire logic [31:0] dma_data,
    output logic dma_ready
);
    logic hold = 1'b0;
    logic slow = 1'b0;
    logic unified = 1'b0;
    logic [32:0] txq[$];
    logic [32:0] rxq[$];
    logic [31:0] dmaq[$];
    initial begin
        {tx_ready, tx_unified, rx_valid, rx_first, dma_ready} = 5'h00;
        rx_data = 32'h0;
    end
    always @(posedge clk) begin
        if (tx_valid && tx_ready) txq.push_back({tx_last, tx_data});
        if (dma_valid && dma_ready) dmaq.push_back(dma_data);
        if (rx_valid && rx_ready) void'(rxq.pop_front());
        // slow mode stalls every other cycle to stress the hold path
        tx_ready <= !hold && (!slow || !tx_ready);
        dma_ready <= !slow || !dma_ready;
        tx_unified <= unified;
        if (rxq.size() > 0) begin
            rx_valid <= 1'b1;
            {rx_first, rx_data} <= rxq[0];
        end else begin
            // idle bus inverts the data each cycle, so the last word returns every other cycle
            rx_valid <= 1'b0;
            rx_first <= 1'b0;
            rx_data <= ~rx_data;
        end
    end
endmodule : acfr_link_model

// ===== acfr_top_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module acfr_top_bench import acfr_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rdata, tx_data, rx_data, dma_data, d;
    logic tx_valid, tx_last, tx_ready, tx_unified, rx_valid, rx_first, rx_ready;
    logic dma_valid, dma_ready;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int tot = 0;
    logic [7:0] ofs [6] = '{OFS_MTX_STAT, OFS_MRX_STAT, OFS_CTX_STAT, OFS_CRX_STAT,
        OFS_GTX_STAT, OFS_GRX_STAT};
    logic [8:0] esz [6] = '{9'h003, 9'h00F, 9'h00C, 9'h03C, 9'h020, 9'h100};
    logic [5:0] lbl [3] = '{6'h21, 6'h32, 6'h01};
    logic [7:0] prt [3] = '{OFS_MRX_READ, OFS_CRX_READ, OFS_GRX_READ};
    always #25 clk = ~clk;
    acfr_top u_acfr_top (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .tx_unified(tx_unified),
        .rx_valid(rx_valid), .rx_first(rx_first), .rx_data(rx_data), .rx_ready(rx_ready),
        .dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready));
    acfr_link_model u_link (.clk(clk), .rst_n(rst_n), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .tx_unified(tx_unified),
        .rx_valid(rx_valid), .rx_first(rx_first), .rx_data(rx_data), .rx_ready(rx_ready),
        .dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready));
    function automatic logic [31:0] hdr(input logic [5:0] lb, input logic [3:0] tc);
        return {16'h0000, lb, 2'b00, tc, 4'h0};
    endfunction : hdr
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask : rd
    task automatic snd(input logic [5:0] lb, input logic [3:0] tc);
        wr(OFS_TX_FIRST, hdr(lb, tc));
        wr(OFS_TX_NEXT, {26'h0, lb});
        wr(OFS_TX_FINAL, {28'h0, tc});
    endtask : snd
    task automatic wait_tx(input int n);
        repeat (400) if (u_link.txq.size() < n) @(posedge clk);
        `CHK(u_link.txq.size() >= n, 1'b1)
        repeat (2) @(posedge clk);
    endtask : wait_tx
    task automatic rsp(input logic [5:0] lb, input logic [3:0] tc, input logic [31:0] b);
        @(posedge clk);
        #1 u_link.rxq.push_back({1'b1, hdr(lb, tc)});
        u_link.rxq.push_back({1'b0, b});
        repeat (100) if (u_link.rxq.size() > 0) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask : rsp
    task automatic conclude;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    // ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i], d);
            `CHK(d[8:0], esz[i])
            tot += d[8:0];
        end
        `CHK(tot, 32'h17A)
        rd(OFS_ORB_CTRL, d);
        `CHK(d[8:0], 9'h008)
        rd(8'h7C, d);
        `CHK(d, 32'h0)
        rd(OFS_GRX_READ, d);
        `CHK(d, 32'h0)
        // general is picked while idle, then priority decides the rest
        u_link.hold = 1'b1;
        snd(6'h01, TC_RD_BLK);
        snd(6'h32, TC_RD_BLK);
        snd(6'h21, TC_RD_BLK);
        wr(OFS_TX_FIRST, hdr(6'h22, TC_RD_BLK));
        rd(OFS_MTX_STAT, d);
        `CHK(d[30], 1'b1)
        u_link.hold = 1'b0;
        wait_tx(9);
        `CHK(u_link.txq[0][31:0], hdr(6'h01, TC_RD_BLK))
        `CHK(u_link.txq[3][31:0], hdr(6'h21, TC_RD_BLK))
        `CHK(u_link.txq[6][31:0], hdr(6'h32, TC_RD_BLK))
        `CHK(u_link.txq[4][32], 1'b0)
        `CHK(u_link.txq[5], 33'h100000005)
        wr(OFS_MTX_STAT, 32'h80000000);
        rd(OFS_MTX_STAT, d);
        `CHK(d[30], 1'b0)
        for (int i = 0; i < 3; i++) begin
            rsp(lbl[i], TC_RD_BRESP, {26'h0, lbl[i]});
            rd(prt[i], d);
            `CHK(d, hdr(lbl[i], TC_RD_BRESP))
            rd(prt[i], d);
            `CHK(d, 32'(lbl[i]))
        end
        u_link.txq.delete();
        u_link.unified = 1'b1;
        snd(6'h04, TC_WR_BLK);
        wait_tx(3);
        u_link.unified = 1'b0;
        rsp(6'h04, TC_WR_RESP, 32'h0000ABCD);
        rd(OFS_GRX_READ, d);
        `CHK(d, 32'h0)
        u_link.txq.delete();
        wr(OFS_USTAT, 32'h3);
        u_link.slow = 1'b1;
        snd(6'h38, TC_WR_BLK);
        wait_tx(3);
        rd(OFS_USTAT, d);
        `CHK(d[1:0], 2'b01)
        u_link.slow = 1'b0;
        rsp(6'h38, TC_WR_RESP, 32'h0);
        rd(OFS_GRX_READ, d);
        `CHK(d, hdr(6'h38, TC_WR_RESP))
        u_link.txq.delete();
        snd(6'h11, TC_RD_BLK);
        wait_tx(3);
        rsp(6'h11, TC_RD_BRESP, 32'h0000D0A0);
        `CHK(u_link.dmaq.size(), 2)
        `CHK(u_link.dmaq[1], 32'h0000D0A0)
        rsp(6'h11, TC_WR_BLK, 32'h0);
        `CHK(u_link.dmaq.size(), 2)
        wr(OFS_CTX_STAT, 32'h80000006);
        wr(OFS_CRX_STAT, 32'h8000001E);
        wr(OFS_ORB_CTRL, 32'h108);
        wr(OFS_CRX_STAT, 32'h80000016);
        rd(OFS_CRX_STAT, d);
        `CHK(d, 32'h16)
        conclude();
    end
endmodule : acfr_top_bench
